// [hdl/stw_ctrl2_regs.sv]
// Purpose: Control two register, three wire start and abort, dual data lines
// Assumes: Serial clock and select are pins, sampled on sys_clk at 40 MHz
// Notes: Bit counting only; shifting of data is done elsewhere
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "stw_map.svh"
module stw_ctrl2_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire stw_pkg::stw_regreq_s regReq,
  output logic [31:0] regRdata,
  // Configuration from other parts of the controller
  input wire logic slaveMode,
  input wire logic levelTrigSlave,
  input wire logic [4:0] transferBitLength,
  input wire logic [1:0] shiftOut,
  // Serial pins
  input wire logic serialClockPin,
  input wire logic selectPin_n,
  input wire logic slaveInPinIn,
  output logic slaveInPinOut,
  output logic slaveInPinOe,
  input wire logic slaveOutPinIn,
  output logic slaveOutPinOut,
  output logic slaveOutPinOe,
  // Synced data lines for the shifter
  output logic [1:0] dataLinesIn,
  // Controls and events to other parts
  output logic clockCompatSelect,
  output logic selectLevelTriggerForce,
  output logic dualIoActive,
  output logic transferDone,
  output logic unitFlagSet,
  output logic irq
);
  import stw_pkg::*;

  // A literal cannot be bit-selected, so the reset word gets a name first
  localparam logic [31:0] CTRL2_RST = `STW_CTRL2_RST;
  localparam stw_state_s ST_RST = '{
    ctrl: '{
      clockCompatSelect: CTRL2_RST[`STW_BIT_COMPAT],
      selectInactiveIrqOption: CTRL2_RST[`STW_BIT_SS_OPT],
      dualEn: CTRL2_RST[`STW_BIT_DUAL_EN],
      dualDir: CTRL2_RST[`STW_BIT_DUAL_DIR],
      threeWireStartIrqEnable: CTRL2_RST[`STW_BIT_START_EN],
      ignoreSelectEnable: CTRL2_RST[`STW_BIT_NO_SEL]
    },
    threeWireStartFlag: CTRL2_RST[`STW_BIT_START_FLAG],
    forceDonePulse: 1'b0,
    busy: 1'b0,
    bitCnt: 6'h00,
    sclkPrev: 1'b0,
    selPrev: 1'b1,
    irqSts: 3'h0,
    irqMask: `STW_IRQ_MASK_RST,
    dOut: 2'h0,
    rdData: 32'h00000000
  };

  stw_state_s st_r;
  stw_state_s st_nxt;
  logic [3:0] pinsS;
  logic sclkS;
  logic selS;
  logic sclkEdge;
  logic sclkRise;
  logic threeWire;
  logic wrCtrl;
  logic wrStat;
  logic wrISts;
  logic wrMask;
  logic countEvt;
  logic [5:0] cntNext;
  logic [5:0] lenBits;
  logic bitDone;
  logic abortEvt;
  logic doneEvt;
  logic startEvt;
  logic flagClr;
  logic ssInactEvt;
  logic driving;
  logic [31:0] ctrlView;

  stw_pin_sync #(
    .W(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din({slaveOutPinIn, slaveInPinIn, ~selectPin_n, serialClockPin}),
    .dout(pinsS)
  );

  assign sclkS = pinsS[0];
  // Select enters inverted so the cleared sync matches an idle pin
  assign selS = ~pinsS[1];
  assign dataLinesIn = pinsS[3:2];

  // Edge finding uses the second sync flop against its own delayed copy
  assign sclkEdge = sclkS ^ st_r.sclkPrev;
  assign sclkRise = sclkS & ~st_r.sclkPrev;
  assign threeWire = slaveMode & st_r.ctrl.ignoreSelectEnable; // [R13]

  assign wrCtrl = regReq.wr && regReq.addr == `STW_OFS_CTRL2;
  assign wrStat = regReq.wr && regReq.addr == `STW_OFS_STATUS;
  assign wrISts = regReq.wr && regReq.addr == `STW_OFS_IRQ_STS;
  assign wrMask = regReq.wr && regReq.addr == `STW_OFS_IRQ_MASK;

  // Zero length means a full word
  assign lenBits = (transferBitLength == 5'h00) ? `STW_FULL_LEN :
                   {1'b0, transferBitLength}; // [R16]
  // Four wire counts only while select is low
  assign countEvt = sclkRise & slaveMode & (threeWire | ~selS); // [R13]
  assign cntNext = st_r.bitCnt + 6'h01;
  assign bitDone = countEvt && cntNext == lenBits; // [R10]
  assign abortEvt = st_r.forceDonePulse & threeWire; // [R11]
  assign doneEvt = bitDone | abortEvt;
  // The edge that ends a transfer must not leave the flag set again
  assign startEvt = threeWire & sclkEdge & ~doneEvt &
                    st_r.ctrl.threeWireStartIrqEnable; // [R5]
  assign flagClr = (wrCtrl & regReq.wdata[`STW_BIT_START_FLAG]) |
                   (wrStat & regReq.wdata[`STW_BIT_START_FLAG]) |
                   doneEvt; // [R7]
  assign ssInactEvt = slaveMode & levelTrigSlave & ~threeWire &
                      st_r.ctrl.selectInactiveIrqOption &
                      selS & ~st_r.selPrev; // [R2]

  assign ctrlView = {st_r.ctrl.clockCompatSelect, 14'h0000,
                     st_r.ctrl.selectInactiveIrqOption, 2'h0,
                     st_r.ctrl.dualEn, st_r.ctrl.dualDir,
                     st_r.threeWireStartFlag,
                     st_r.ctrl.threeWireStartIrqEnable, 1'b0,
                     st_r.ctrl.ignoreSelectEnable, 8'h00}; // [R17]

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclkPrev = sclkS;
    st_nxt.selPrev = selS;
    st_nxt.dOut = shiftOut;
    st_nxt.forceDonePulse = 1'b0;
    st_nxt.rdData = 32'h00000000;
    if (wrCtrl) begin
      st_nxt.ctrl.clockCompatSelect = regReq.wdata[`STW_BIT_COMPAT]; // [R1]
      st_nxt.ctrl.selectInactiveIrqOption = regReq.wdata[`STW_BIT_SS_OPT];
      st_nxt.ctrl.dualEn = regReq.wdata[`STW_BIT_DUAL_EN];
      st_nxt.ctrl.dualDir = regReq.wdata[`STW_BIT_DUAL_DIR];
      st_nxt.ctrl.threeWireStartIrqEnable = regReq.wdata[`STW_BIT_START_EN];
      st_nxt.ctrl.ignoreSelectEnable = regReq.wdata[`STW_BIT_NO_SEL];
      st_nxt.forceDonePulse = regReq.wdata[`STW_BIT_ABORT]; // [R12]
    end
    // Set beats clear when both land in one cycle
    st_nxt.threeWireStartFlag = startEvt |
                                (st_r.threeWireStartFlag & ~flagClr); // [R6]
    // Hardware drop of the enable overrides a same cycle write
    if (doneEvt || (st_r.threeWireStartFlag && flagClr && !startEvt)) begin
      st_nxt.ctrl.threeWireStartIrqEnable = 1'b0; // [R9]
    end
    if (doneEvt) begin
      st_nxt.busy = 1'b0;
    end else if (threeWire) begin
      // Only a rise opens a frame; the trailing fall after done stays idle
      st_nxt.busy = st_r.busy | sclkRise;
    end else begin
      st_nxt.busy = slaveMode & ~selS;
    end
    if (doneEvt || (!threeWire && selS)) begin
      st_nxt.bitCnt = 6'h00;
    end else if (countEvt) begin
      st_nxt.bitCnt = cntNext; // [R10]
    end
    if (wrISts) begin
      st_nxt.irqSts = st_r.irqSts & ~regReq.wdata[2:0];
    end
    st_nxt.irqSts = st_nxt.irqSts |
                    {ssInactEvt, doneEvt, startEvt}; // [R8]
    if (wrMask) begin
      st_nxt.irqMask = regReq.wdata[2:0];
    end
    if (regReq.rd) begin
      case (regReq.addr)
        `STW_OFS_CTRL2: begin
          st_nxt.rdData = ctrlView;
        end
        `STW_OFS_STATUS: begin
          st_nxt.rdData[`STW_BIT_START_FLAG] = st_r.threeWireStartFlag; // [R6]
        end
        `STW_OFS_IRQ_STS: begin
          st_nxt.rdData = {29'h00000000, st_r.irqSts};
        end
        `STW_OFS_IRQ_MASK: begin
          st_nxt.rdData = {29'h00000000, st_r.irqMask};
        end
        default: begin
          st_nxt.rdData = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drive: dual input leaves both lines free, dual output drives both
  assign driving = st_r.busy & slaveMode;
  assign dualIoActive = st_r.ctrl.dualEn; // [R3]
  assign slaveOutPinOe = driving &
                         ~(st_r.ctrl.dualEn & ~st_r.ctrl.dualDir); // [R4]
  assign slaveInPinOe = driving & st_r.ctrl.dualEn &
                        st_r.ctrl.dualDir; // [R3] [R4]
  assign slaveOutPinOut = st_r.dOut[0];
  assign slaveInPinOut = st_r.dOut[1];

  assign regRdata = st_r.rdData;
  assign clockCompatSelect = st_r.ctrl.clockCompatSelect; // [R1]
  assign selectLevelTriggerForce = threeWire; // [R14]
  assign transferDone = doneEvt;
  assign unitFlagSet = doneEvt | ssInactEvt; // [R2]
  assign irq = |(st_r.irqSts & st_r.irqMask);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_abort_write;
    wrCtrl && regReq.wdata[`STW_BIT_ABORT] && slaveMode &&
    regReq.wdata[`STW_BIT_NO_SEL];
  endsequence

  sequence seq_forced_done;
    abortEvt ##1 (st_r.irqSts[1] && !st_r.busy);
  endsequence

  chk_abort_forces_done: assert property ( // [R11]
    seq_abort_write |=> seq_forced_done
  ) else $error("Abort write did not force a done event");

  chk_abort_self_clear: assert property ( // [R12]
    st_r.forceDonePulse |=> !st_r.forceDonePulse
  ) else $error("Abort pulse held more than one cycle");

  chk_flag_cause: assert property ( // [R5]
    $rose(st_r.threeWireStartFlag) |->
      $past(threeWire) && $past(st_r.ctrl.threeWireStartIrqEnable)
  ) else $error("Start flag set without enabled three wire edge");

  chk_done_clears_flag: assert property ( // [R7]
    doneEvt |=> !st_r.threeWireStartFlag
  ) else $error("Start flag survived transfer done");

  chk_enable_drop: assert property ( // [R9]
    doneEvt |=> !st_r.ctrl.threeWireStartIrqEnable
  ) else $error("Start enable not cleared at done");

  chk_status_mirror: assert property ( // [R6]
    (regReq.rd && regReq.addr == `STW_OFS_STATUS) |=>
      regRdata[`STW_BIT_START_FLAG] == $past(st_r.threeWireStartFlag)
  ) else $error("Status view differs from start flag");

  chk_count_done: assert property ( // [R10]
    bitDone |=> (st_r.bitCnt == 6'h00) && st_r.irqSts[1]
  ) else $error("Bit count did not close the transfer");

  chk_dual_lines: assert property ( // [R4]
    (st_r.ctrl.dualEn && !st_r.ctrl.dualDir) |->
      !slaveOutPinOe && !slaveInPinOe
  ) else $error("Dual input mode drives a data line");

  chk_dual_off: assert property ( // [R3]
    !st_r.ctrl.dualEn |-> !slaveInPinOe
  ) else $error("Second line driven with dual mode off");

  chk_select_irq: assert property ( // [R2]
    (!st_r.ctrl.selectInactiveIrqOption || threeWire) |-> !ssInactEvt
  ) else $error("Inactive select event without option");

  chk_force_trigger: assert property ( // [R14]
    threeWire |-> selectLevelTriggerForce
  ) else $error("Level trigger not forced in three wire mode");

  chk_start_irq: assert property ( // [R8]
    startEvt |=> st_r.irqSts[0]
  ) else $error("Start event did not set its status bit");

  chk_inactive_irq: assert property ( // [R2]
    ssInactEvt |-> unitFlagSet ##1 st_r.irqSts[2]
  ) else $error("Inactive select event not recorded");

  chk_reserved_zero: assert property ( // [R17]
    (regReq.rd && regReq.addr == `STW_OFS_CTRL2) |=>
      regRdata[30:17] == 14'h0000 && regRdata[15:14] == 2'h0 &&
      regRdata[9] == 1'b0 && regRdata[7:0] == 8'h00
  ) else $error("Reserved or abort bits read as one");

  chk_flag_hold: assert property ( // [R7]
    (st_r.threeWireStartFlag && !flagClr) |=> st_r.threeWireStartFlag
  ) else $error("Start flag lost without a clear");
endmodule
`default_nettype wire

// [common/stw_map.svh]
// Purpose: Offsets, field positions, reset values of the control two block
// Assumes: Register offsets are byte addresses on the plain register port
// Notes: Constants only, no logic
//
// Overview of operation
// (R1) Bit 31 picks backward compatible clock setup (0) or the newer one (1).
// (R2) Level trigger slave: bit 16 set lets inactive select raise unit flag.
// (R3) Dual data line mode runs only while bit 13 is one.
// (R4) In dual mode bit 12 zero receives, one transmits on both lines.
// (R5) Three wire: bit 11 sets on clock transition once start enable set.
// (R6) Bit 11 is one flop, seen here and at status bit 11.
// (R7) Start flag clears at transfer end or on writing one; zero does nothing.
// (R8) Bit 10 enables an interrupt when a three wire transfer begins.
// (R9) Hardware clears start enable at transfer end or when start flag clears.
// (R10) Transfer done event when counted bits reach the transfer bit length.
// (R11) Writing one to bit 9 forces the three wire transfer done now.
// (R12) The abort bit clears itself; it acts as a one cycle pulse.
// (R13) Bit 8 one ignores select, three wire; zero uses four wires.
// (R14) Three wire mode forces the select level trigger setting to one.
// (R15) Software aborts if no done interrupt arrives within its own timeout.
// (R16) Transfer bit length gives bits per transfer; zero means 32.
// (R17) Reserved bits read zero and ignore writes.
`ifndef STW_MAP_SVH
`define STW_MAP_SVH
`define STW_OFS_CTRL2 8'h3C
`define STW_OFS_STATUS 8'h44
`define STW_OFS_IRQ_STS 8'h50
`define STW_OFS_IRQ_MASK 8'h54
`define STW_BIT_COMPAT 31
`define STW_BIT_SS_OPT 16
`define STW_BIT_DUAL_EN 13
`define STW_BIT_DUAL_DIR 12
`define STW_BIT_START_FLAG 11
`define STW_BIT_START_EN 10
`define STW_BIT_ABORT 9
`define STW_BIT_NO_SEL 8
`define STW_CTRL2_RST 32'h00001000
`define STW_IRQ_MASK_RST 3'h7
`define STW_FULL_LEN 6'h20
`define STW_SYNC_STAGES 2
`endif

// [common/stw_pkg.sv]
// Purpose: Types shared by the control two block
// Assumes: Constants live in stw_map.svh
// Notes: State structs hold all flops of each module
package stw_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } stw_regreq_s;

  typedef struct packed {
    logic clockCompatSelect;
    logic selectInactiveIrqOption;
    logic dualEn;
    logic dualDir;
    logic threeWireStartIrqEnable;
    logic ignoreSelectEnable;
  } stw_ctrl_s;

  typedef struct packed {
    logic first;
    logic second;
  } stw_sync_s;

  typedef struct packed {
    stw_ctrl_s ctrl;
    logic threeWireStartFlag;
    logic forceDonePulse;
    logic busy;
    logic [5:0] bitCnt;
    logic sclkPrev;
    logic selPrev;
    logic [2:0] irqSts;
    logic [2:0] irqMask;
    logic [1:0] dOut;
    logic [31:0] rdData;
  } stw_state_s;
endpackage

// [hdl/stw_pin_sync.sv]
// Purpose: Two flop synchroniser for pins entering the sys_clk domain
// Assumes: Inputs are asynchronous levels
// Notes: Only the second flop is visible outside
`timescale 1ns/10ps
`default_nettype none
module stw_pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import stw_pkg::*;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      stw_sync_s st_r;
      stw_sync_s st_nxt;
      always_comb begin
        st_nxt.first = din[i];
        st_nxt.second = st_r.first;
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          st_r <= '0;
        end else begin
          st_r <= st_nxt;
        end
      end
      assign dout[i] = st_r.second;
    end
  endgenerate
endmodule
`default_nettype wire

// [sim/stw_spi_master.sv]
// Purpose: Serial master model that drives clock, select and data lines
// Assumes: Clock idles low and stands still between frames
// Notes: Released data lines toggle so a stale level never passes
`timescale 1ns/10ps
`default_nettype none
module stw_spi_master (
  // Serial lines
  output logic sclk,
  output logic selN,
  output logic mosi,
  output logic miso
);
  logic active;
  logic [31:0] pat;
  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    mosi = 1'b0;
    miso = 1'b1;
    active = 1'b0;
    pat = 32'hA5C396E1;
  end
  // Lines not driven in a frame flip every 50 ns
  always #50 if (!active) begin
    mosi = ~mosi;
    miso = ~miso;
  end
  // One frame of n clocks; half sets the pace, useSel drives select low
  task automatic frame(input int n, input int half, input bit useSel);
    active = 1'b1;
    selN = !useSel;
    for (int i = 0; i < n; i++) begin
      mosi = pat[i % 32];
      miso = ~pat[i % 32];
      #(half) sclk = 1'b1;
      #(half) sclk = 1'b0;
    end
    #(half) selN = 1'b1;
    active = 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/spi_slave_three_wire_dual_io_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the control two block
// Assumes: Register port reads answer in the cycle after the strobe
// Notes: Shifter data held constant, so pin outputs are easy to predict
`timescale 1ns/10ps
`default_nettype none
module spi_slave_three_wire_dual_io_ctrl_tb_top;
  import stw_pkg::*;
  logic sys_clk, rst_n, slaveMode, levelTrigSlave;
  stw_regreq_s regReq;
  logic [31:0] regRdata;
  logic [4:0] bitLen;
  logic [1:0] shiftOut, dataLinesIn;
  logic sclk, selN, mosi, miso, siWire, soWire;
  logic siOut, siOe, soOut, soOe;
  logic compat, ltForce, dualAct, done, uflag, irq;
  int errCount = 0, checked = 0, doneCnt = 0, flagCnt = 0, d0, u0;
  logic [31:0] cfg [3] = '{32'h3000, 32'h2000, 32'h0};
  logic [1:0] oe [3] = '{2'b11, 2'b00, 2'b01};

  assign siWire = siOe ? siOut : mosi;
  assign soWire = soOe ? soOut : miso;

  stw_ctrl2_regs i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdata(regRdata), .slaveMode(slaveMode),
    .levelTrigSlave(levelTrigSlave), .transferBitLength(bitLen),
    .shiftOut(shiftOut), .serialClockPin(sclk), .selectPin_n(selN),
    .slaveInPinIn(siWire), .slaveInPinOut(siOut), .slaveInPinOe(siOe),
    .slaveOutPinIn(soWire), .slaveOutPinOut(soOut),
    .slaveOutPinOe(soOe), .dataLinesIn(dataLinesIn),
    .clockCompatSelect(compat), .selectLevelTriggerForce(ltForce),
    .dualIoActive(dualAct), .transferDone(done), .unitFlagSet(uflag),
    .irq(irq)
  );
  stw_spi_master i_master (
    .sclk(sclk), .selN(selN), .mosi(mosi), .miso(miso)
  );

  always @(posedge sys_clk) begin
    if (done === 1'b1) doneCnt++;
    if (uflag === 1'b1) flagCnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regReq.addr <= a;
    regReq.wdata <= d;
    regReq.wr <= 1'b1;
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
    // Callers look at outputs only once this edge's updates have settled
    #1;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic testDone;
    if (errCount == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Hang guard: a stuck run counts as a failure
  initial begin
    #1ms;
    errCount++;
    testDone;
  end

  initial begin
    rst_n = 1'b0;
    regReq = '0;
    slaveMode = 1'b0;
    levelTrigSlave = 1'b0;
    bitLen = 5'h04;
    shiftOut = 2'b10;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdChk(8'h3C, 32'h00001000);
    rdChk(8'h54, 32'h00000007);
    rdChk(8'h50, 32'h00000000);
    rdChk(8'h80, 32'h00000000);
    // Flag and abort kept 0 so no clear or done side effect muddies this
    wrReg(8'h3C, 32'hFFFFF5FF);
    rdChk(8'h3C, 32'h80013500);
    chk(compat, 1'b1);
    chk(dualAct, 1'b1);
    chk(ltForce, 1'b0);
    wrReg(8'h3C, 32'h0);
    rdChk(8'h3C, 32'h0);
    chk({compat, dualAct}, 2'b00);
    // Three wire transfer with select left high
    slaveMode <= 1'b1;
    wrReg(8'h3C, 32'h500);
    chk(ltForce, 1'b1);
    d0 = doneCnt;
    fork
      i_master.frame(4, 100, 1'b0);
      begin
        repeat (12) @(posedge sys_clk);
        rdChk(8'h44, 32'h800);
        rdChk(8'h3C, 32'hD00);
        chk(irq, 1'b1);
      end
    join
    repeat (6) @(posedge sys_clk);
    chk(doneCnt - d0, 1);
    rdChk(8'h3C, 32'h100);
    wrReg(8'h54, 32'h0);
    rdChk(8'h50, 32'h3);
    chk(irq, 1'b0);
    wrReg(8'h54, 32'h7);
    rdChk(8'h54, 32'h7);
    chk(irq, 1'b1);
    wrReg(8'h50, 32'h7);
    rdChk(8'h50, 32'h0);
    chk(irq, 1'b0);
    // Partial transfer, flag cleared through the status view, then abort
    bitLen <= 5'h08;
    wrReg(8'h3C, 32'h500);
    i_master.frame(2, 100, 1'b0);
    wrReg(8'h3C, 32'h500);
    rdChk(8'h3C, 32'hD00);
    wrReg(8'h44, 32'h800);
    rdChk(8'h3C, 32'h100);
    d0 = doneCnt;
    wrReg(8'h3C, 32'h300);
    rdChk(8'h3C, 32'h100);
    chk(doneCnt - d0, 1);
    // Length code zero: 31 clocks give no done, the 32nd does
    bitLen <= 5'h00;
    i_master.frame(31, 100, 1'b0);
    chk(doneCnt - d0, 1);
    i_master.frame(1, 100, 1'b0);
    repeat (4) @(posedge sys_clk);
    chk(doneCnt - d0, 2);
    // Four wire level trigger slave, inactive select option on and off
    bitLen <= 5'h04;
    levelTrigSlave <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wrReg(8'h3C, k ? 32'h0 : 32'h10000);
      chk(ltForce, 1'b0);
      wrReg(8'h50, 32'h7);
      u0 = flagCnt;
      i_master.frame(4, 100, 1'b1);
      repeat (6) @(posedge sys_clk);
      rdChk(8'h50, k ? 32'h2 : 32'h6);
      chk(flagCnt - u0, k ? 1 : 2);
    end
    // Pin drive by dual mode setting, checked mid frame
    for (int k = 0; k < 3; k++) begin
      wrReg(8'h3C, cfg[k]);
      fork
        i_master.frame(8, 100, 1'b1);
        begin
          repeat (20) @(posedge sys_clk);
          #1 chk({siOe, soOe}, oe[k]);
          chk({siOut, soOut}, 2'b10);
          chk(dataLinesIn, {soWire, siWire});
        end
      join
    end
    testDone;
  end
endmodule
`default_nettype wire
